/* File: rtl/rism_pkg.sv */
// Constants, field positions and carrier types of the radio interrupt source mapping block.
// Overview of operation
// - Continuous receive/standby: first pin gives sync, or signal level for selector 01.
// - Buffered receive first pin: none, byte written, not-empty, sync.
// - Packet receive first pin: payload ready, byte written, not-empty, sync or address match.
// - Second pin receive: bit clock continuous; buffered none/full/level/threshold; packet CRC good first.
// - Not-empty, full and threshold sources stay routable in standby too.
// - Transmit second pin: bit clock continuous, else full (0) or transmit done (1).
// - Read-only queue-full status at bit 2.
// - Active-high queue-not-empty status at bit 1.
// - Sticky overrun flag at bit 0; writing 1 clears flag and queue.
// - Fill-method bit picks automatic sync-start filling or manual fill control.
// - Automatic fill bit rises on sync; writing 1 clears and re-arms unless overrun.
// - Manual filling follows the fill bit written by the host.
// - Read-only transmit-done flag at bit 5 after last bit leaves shifter.
// - Buffered transmit start: full (0) or not empty (1); first pin not-empty.
// - Packet transmit start: threshold reached (0) or not empty (1), with matching pin.
// - Bit 3 enables the signal-level source, resets to 0.
// - Sticky signal-level flag sets above threshold, cleared by writing 1.
// - Lock status bit shows synthesizer lock, cleared by writing 1.
// - Lock-detect enable drives lock output, else releases it.
// - Eight-bit signal-level threshold, reset zero, sets the flag trigger level.
package rism_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [3:0] RISM_IDX_SEL = 4'hD;
  localparam logic [3:0] RISM_IDX_FILL = 4'hE;
  localparam logic [3:0] RISM_IDX_THR = 4'hF;
  localparam logic [7:0] RISM_ADDR_SEL = {2'h0, RISM_IDX_SEL, 2'h0};
  localparam logic [7:0] RISM_ADDR_FILL = {2'h0, RISM_IDX_FILL, 2'h0};
  localparam logic [7:0] RISM_ADDR_THR = {2'h0, RISM_IDX_THR, 2'h0};
  localparam logic [7:0] RISM_ADDR_MODE = 8'h40;
  // Field positions.
  localparam int RISM_B_IRQ0_HI = 7;
  localparam int RISM_B_IRQ0_LO = 6;
  localparam int RISM_B_IRQ1_HI = 5;
  localparam int RISM_B_IRQ1_LO = 4;
  localparam int RISM_B_TXIRQ1 = 3;
  localparam int RISM_B_FULL = 2;
  localparam int RISM_B_NEMPTY = 1;
  localparam int RISM_B_OVR = 0;
  localparam int RISM_B_METHOD = 7;
  localparam int RISM_B_FILL = 6;
  localparam int RISM_B_TXDONE = 5;
  localparam int RISM_B_TXSTART = 4;
  localparam int RISM_B_LVLEN = 3;
  localparam int RISM_B_LVL = 2;
  localparam int RISM_B_LOCK = 1;
  localparam int RISM_B_LOCKEN = 0;
  // Reset values.
  localparam logic [1:0] RISM_RST_SEL2 = 2'h0;
  localparam logic RISM_RST_BIT0 = 1'b0;
  localparam logic RISM_RST_LOCKEN = 1'b1;
  localparam logic [7:0] RISM_RST_THR = 8'h00;
  localparam logic [31:0] RISM_RST_WORD = 32'h00000000;

  typedef enum logic [1:0] {RISM_DM_CONT, RISM_DM_BUF, RISM_DM_PKT, RISM_DM_PKT2} rism_dmode_e;
  typedef enum logic [1:0] {RISM_OM_STBY, RISM_OM_RX, RISM_OM_TX, RISM_OM_SLEEP} rism_omode_e;

  // Events and levels from the data path.
  typedef struct packed {
    logic sync;
    logic addr_match;
    logic payload_ready;
    logic byte_written;
    logic crc_ok;
    logic bit_clock;
    logic last_bit_out;
    logic overrun;
    logic pll_lock;
  } rism_evt_s;

  // Queue state seen by the block.
  typedef struct packed {
    logic full;
    logic empty;
    logic at_threshold;
  } rism_q_s;
endpackage

/* File: rtl/rism_sync2.sv */
// Two-stage synchroniser for a bus of pin levels.
`timescale 1ns/10ps
module rism_sync2 import rism_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Levels.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be at least one");
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end
  assign o_sync = sync_reg;
endmodule

/* File: rtl/rism_level_cmp.sv */
// Signal-level comparator against the programmed threshold.
`timescale 1ns/10ps
module rism_level_cmp import rism_pkg::*; #(
  parameter int WIDTH = 8
) (
  // Operands.
  input wire logic [WIDTH-1:0] i_level,
  input wire logic [WIDTH-1:0] i_threshold,
  input wire logic i_enable,
  // Result.
  output logic o_above
);
  initial begin
    if (WIDTH < 1) $error("WIDTH must be at least one");
  end
  // Strictly above, so a zero threshold still ignores a zero reading.
  assign o_above = i_enable && (i_level > i_threshold);
endmodule

/* File: rtl/rism_top.sv */
// Interrupt source mapping, status flags and APB register file.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module rism_top import rism_pkg::*; #(
  parameter int LVL_W = 8
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Data path events, same clock.
  input wire rism_evt_s i_evt,
  input wire rism_q_s i_q,
  input wire logic [LVL_W-1:0] i_level,
  input wire logic i_addr_filter_en,
  // Recovered bit clock from a pin.
  input wire logic i_bit_clock_pin,
  // Fill and transmit control.
  output logic o_fill_en,
  output logic o_queue_clear,
  output logic o_tx_start,
  // Interrupt and lock pins.
  output logic o_irq0,
  output logic o_irq1,
  output logic o_lock_out,
  output logic o_lock_oe_n
);
  // ****************************************
  // Registers
  // ****************************************
  logic [1:0] irq0_sel_reg;
  logic [1:0] irq1_sel_reg;
  logic tx_irq1_reg;
  logic overrun_reg;
  logic method_reg;
  logic fill_reg;
  logic tx_done_reg;
  logic tx_start_sel_reg;
  logic lvl_en_reg;
  logic lvl_flag_reg;
  logic lock_reg;
  logic lock_en_reg;
  logic [7:0] thr_reg;
  logic [1:0] dmode_reg;
  logic [1:0] omode_reg;
  logic [31:0] rdata_reg;
  logic bit_clock_s;

  initial begin
    if (LVL_W != 8) $error("LVL_W must be 8 to match the threshold field");
  end

  rism_sync2 #(.WIDTH(1)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_bit_clock_pin),
    .o_sync(bit_clock_s)
  );

  logic lvl_above;
  rism_level_cmp #(.WIDTH(LVL_W)) u_cmp (
    .i_level(i_level),
    .i_threshold(thr_reg),
    .i_enable(lvl_en_reg),
    .o_above(lvl_above)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  wire access = i_psel && i_penable;
  wire wr = access && i_pwrite;
  wire hit_sel = i_paddr == RISM_ADDR_SEL;
  wire hit_fill = i_paddr == RISM_ADDR_FILL;
  wire hit_thr = i_paddr == RISM_ADDR_THR;
  wire hit_mode = i_paddr == RISM_ADDR_MODE;
  wire hit_any = hit_sel || hit_fill || hit_thr || hit_mode;
  wire wr_sel = wr && hit_sel;
  wire wr_fill = wr && hit_fill;
  wire wr_thr = wr && hit_thr;
  wire wr_mode = wr && hit_mode;
  wire clr_ovr = wr_sel && i_pwdata[RISM_B_OVR];
  wire clr_fill = wr_fill && i_pwdata[RISM_B_FILL];
  wire clr_lvl = wr_fill && i_pwdata[RISM_B_LVL];
  wire clr_lock = wr_fill && i_pwdata[RISM_B_LOCK];
  wire is_cont = dmode_reg == RISM_DM_CONT;
  wire is_buf = dmode_reg == RISM_DM_BUF;
  wire is_pkt = dmode_reg[1];
  wire is_tx = omode_reg == RISM_OM_TX;
  wire nempty = !i_q.empty;

  // ****************************************
  // Read data
  // ****************************************
  wire [7:0] sel_word = {irq0_sel_reg, irq1_sel_reg, tx_irq1_reg, i_q.full, nempty, overrun_reg};
  wire [7:0] fill_word = {method_reg, fill_reg, tx_done_reg, tx_start_sel_reg, lvl_en_reg, lvl_flag_reg,
                          lock_reg, lock_en_reg};
  wire [31:0] rd_mux = hit_sel ? {24'h000000, sel_word} :
                       hit_fill ? {24'h000000, fill_word} :
                       hit_thr ? {24'h000000, thr_reg} :
                       hit_mode ? {28'h0000000, omode_reg, dmode_reg} : RISM_RST_WORD;
  // Captured in the setup cycle and held through the access edge, so the master samples a settled word.
  wire rd_load = i_psel && !i_penable;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      irq0_sel_reg <= RISM_RST_SEL2;
      irq1_sel_reg <= RISM_RST_SEL2;
      tx_irq1_reg <= RISM_RST_BIT0;
      method_reg <= RISM_RST_BIT0;
      tx_start_sel_reg <= RISM_RST_BIT0;
      lvl_en_reg <= RISM_RST_BIT0;
      lock_en_reg <= RISM_RST_LOCKEN;
      thr_reg <= RISM_RST_THR;
      dmode_reg <= RISM_RST_SEL2;
      omode_reg <= RISM_RST_SEL2;
    end else begin
      if (wr_sel) begin
        irq0_sel_reg <= i_pwdata[RISM_B_IRQ0_HI:RISM_B_IRQ0_LO];
        irq1_sel_reg <= i_pwdata[RISM_B_IRQ1_HI:RISM_B_IRQ1_LO];
        tx_irq1_reg <= i_pwdata[RISM_B_TXIRQ1];
      end
      if (wr_fill) begin
        method_reg <= i_pwdata[RISM_B_METHOD];
        tx_start_sel_reg <= i_pwdata[RISM_B_TXSTART];
        lvl_en_reg <= i_pwdata[RISM_B_LVLEN];
        lock_en_reg <= i_pwdata[RISM_B_LOCKEN];
      end
      if (wr_thr) begin
        thr_reg <= i_pwdata[7:0];
      end
      if (wr_mode) begin
        dmode_reg <= i_pwdata[1:0];
        omode_reg <= i_pwdata[3:2];
      end
    end
  end

  // ****************************************
  // Sticky flags
  // ****************************************
  // Hardware set wins over a software clear in the same cycle.
  wire ovr_next = i_evt.overrun || (overrun_reg && !clr_ovr);
  wire lvl_next = lvl_above || (lvl_flag_reg && !clr_lvl);
  wire lock_next = i_evt.pll_lock || (lock_reg && !clr_lock);
  wire txd_next = i_evt.last_bit_out || (tx_done_reg && !(wr_sel || wr_fill));
  // Automatic mode: re-arm only when no overrun is pending.
  wire auto_rearm = clr_fill && !overrun_reg;
  wire auto_fill_next = (i_evt.sync && !fill_reg) || (fill_reg && !auto_rearm);
  wire man_fill_next = wr_fill ? i_pwdata[RISM_B_FILL] : fill_reg;
  wire method_now = wr_fill ? i_pwdata[RISM_B_METHOD] : method_reg;
  wire fill_next = method_now ? man_fill_next : auto_fill_next;

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      overrun_reg <= RISM_RST_BIT0;
      lvl_flag_reg <= RISM_RST_BIT0;
      lock_reg <= RISM_RST_BIT0;
      tx_done_reg <= RISM_RST_BIT0;
      fill_reg <= RISM_RST_BIT0;
      rdata_reg <= RISM_RST_WORD;
    end else begin
      overrun_reg <= ovr_next;
      lvl_flag_reg <= lvl_next;
      lock_reg <= lock_next;
      tx_done_reg <= txd_next;
      fill_reg <= fill_next;
      if (rd_load) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ****************************************
  // Source selection
  // ****************************************
  // Pins are combinational so a selector change shows in the same cycle.
  logic irq0_mux;
  logic irq1_mux;
  always_comb begin
    irq0_mux = 1'b0;
    if (is_tx) begin
      if (is_pkt && !tx_start_sel_reg) begin
        irq0_mux = i_q.at_threshold;
      end else if (!is_cont) begin
        irq0_mux = nempty;
      end
    end else if (is_cont) begin
      irq0_mux = (irq0_sel_reg == 2'h1) ? lvl_flag_reg : i_evt.sync;
    end else begin
      unique case (irq0_sel_reg)
        2'h0: irq0_mux = is_pkt ? i_evt.payload_ready : 1'b0;
        2'h1: irq0_mux = i_evt.byte_written;
        2'h2: irq0_mux = nempty;
        2'h3: irq0_mux = (is_pkt && i_addr_filter_en) ? i_evt.addr_match : i_evt.sync;
      endcase
    end
  end

  always_comb begin
    irq1_mux = 1'b0;
    if (is_cont) begin
      irq1_mux = bit_clock_s;
    end else if (is_tx) begin
      irq1_mux = tx_irq1_reg ? tx_done_reg : i_q.full;
    end else begin
      unique case (irq1_sel_reg)
        2'h0: irq1_mux = is_pkt ? i_evt.crc_ok : 1'b0;
        2'h1: irq1_mux = i_q.full;
        2'h2: irq1_mux = lvl_flag_reg;
        2'h3: irq1_mux = i_q.at_threshold;
      endcase
    end
  end

  assign o_irq0 = irq0_mux;
  assign o_irq1 = irq1_mux;

  // ****************************************
  // Outputs
  // ****************************************
  wire tx_cond = is_buf ? (tx_start_sel_reg ? nempty : i_q.full) :
                 (tx_start_sel_reg ? nempty : i_q.at_threshold);
  assign o_tx_start = is_tx && !is_cont && tx_cond;
  assign o_fill_en = is_buf && fill_reg;
  assign o_queue_clear = clr_ovr;
  assign o_lock_out = lock_reg && lock_en_reg;
  assign o_lock_oe_n = !lock_en_reg;
  assign o_prdata = rdata_reg;
  assign o_pready = access;
  assign o_pslverr = access && !hit_any;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_clr_ovr;
    clr_ovr && !i_evt.overrun;
  endsequence
  property p_ovr_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n) s_clr_ovr |=> !overrun_reg;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
  property p_ovr_set;
    @(posedge i_ref_clk) disable iff (!i_reset_n) i_evt.overrun |=> overrun_reg;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not set");
  property p_lvl_set;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (lvl_en_reg && i_level > thr_reg) |=> lvl_flag_reg;
  endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("level flag not set");
  property p_lvl_off;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (!lvl_en_reg && !lvl_flag_reg) |=> !lvl_flag_reg;
  endproperty
  a_lvl_off: assert property (p_lvl_off) else $error("level flag set while disabled");
  property p_rearm_blocked;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (clr_fill && !i_pwdata[RISM_B_METHOD] && fill_reg && overrun_reg) |=> fill_reg;
  endproperty
  a_rearm_blocked: assert property (p_rearm_blocked) else $error("fill lost");
  property p_lock_oe;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (o_lock_oe_n == !lock_en_reg) && !(o_lock_oe_n && o_lock_out);
  endproperty
  a_lock_oe: assert property (p_lock_oe) else $error("lock pin enable wrong");
  property p_tx_irq1;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (is_tx && !is_cont) |-> o_irq1 == (tx_irq1_reg ? tx_done_reg : i_q.full);
  endproperty
  a_tx_irq1: assert property (p_tx_irq1) else $error("tx irq1 source wrong");
  property p_cont_irq0;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (!is_tx && is_cont && irq0_sel_reg != 2'h1) |-> o_irq0 == i_evt.sync;
  endproperty
  a_cont_irq0: assert property (p_cont_irq0) else $error("continuous irq0 wrong");
  property p_txdone;
    @(posedge i_ref_clk) disable iff (!i_reset_n) i_evt.last_bit_out |=> tx_done_reg;
  endproperty
  a_txdone: assert property (p_txdone) else $error("tx done not raised");
  // Read data must not move at the access edge, or a master sampling there would race the load.
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence
  property p_rdata_held;
    @(posedge i_ref_clk) disable iff (!i_reset_n) s_setup ##1 s_access |-> o_prdata == $past(rd_mux);
  endproperty
  a_rdata_held: assert property (p_rdata_held) else $error("read data moved");
  property p_lvl_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (clr_lvl && !lvl_above) |=> !lvl_flag_reg;
  endproperty
  a_lvl_clear: assert property (p_lvl_clear) else $error("level flag not cleared");
  property p_lock_set;
    @(posedge i_ref_clk) disable iff (!i_reset_n) i_evt.pll_lock |=> lock_reg;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock flag not set");
  property p_lock_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (clr_lock && !i_evt.pll_lock) |=> !lock_reg;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock flag not cleared");
  sequence s_rearm_req;
    clr_fill && !i_pwdata[RISM_B_METHOD] && !overrun_reg && !i_evt.sync;
  endsequence
  property p_rearm;
    @(posedge i_ref_clk) disable iff (!i_reset_n) s_rearm_req |=> !fill_reg;
  endproperty
  a_rearm: assert property (p_rearm) else $error("fill not re-armed");
  sequence s_sync_seen;
    !method_reg && !wr_fill && i_evt.sync;
  endsequence
  property p_sync_fill;
    @(posedge i_ref_clk) disable iff (!i_reset_n) s_sync_seen |=> fill_reg;
  endproperty
  a_sync_fill: assert property (p_sync_fill) else $error("fill not started on sync");
  property p_man_fill;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (wr_fill && i_pwdata[RISM_B_METHOD]) |=> fill_reg == $past(i_pwdata[RISM_B_FILL]);
  endproperty
  a_man_fill: assert property (p_man_fill) else $error("manual fill not followed");
  property p_fill_mode;
    @(posedge i_ref_clk) disable iff (!i_reset_n) !is_buf |-> !o_fill_en;
  endproperty
  a_fill_mode: assert property (p_fill_mode) else $error("filling outside buffered mode");
  property p_qclr;
    @(posedge i_ref_clk) disable iff (!i_reset_n) o_queue_clear |-> (wr_sel && i_pwdata[RISM_B_OVR]);
  endproperty
  a_qclr: assert property (p_qclr) else $error("queue cleared without request");
  property p_txd_clear;
    @(posedge i_ref_clk) disable iff (!i_reset_n) ((wr_sel || wr_fill) && !i_evt.last_bit_out) |=> !tx_done_reg;
  endproperty
  a_txd_clear: assert property (p_txd_clear) else $error("tx done not cleared");
  property p_tx_irq0_buf;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (is_tx && is_buf) |-> o_irq0 == !i_q.empty;
  endproperty
  a_tx_irq0_buf: assert property (p_tx_irq0_buf) else $error("buffered tx irq0 wrong");
  property p_tx_irq0_pkt;
    @(posedge i_ref_clk) disable iff (!i_reset_n)
      (is_tx && is_pkt && !tx_start_sel_reg) |-> o_irq0 == i_q.at_threshold;
  endproperty
  a_tx_irq0_pkt: assert property (p_tx_irq0_pkt) else $error("packet tx irq0 wrong");
  property p_cont_irq1;
    @(posedge i_ref_clk) disable iff (!i_reset_n) is_cont |-> o_irq1 == bit_clock_s;
  endproperty
  a_cont_irq1: assert property (p_cont_irq1) else $error("continuous irq1 wrong");
  property p_tx_start;
    @(posedge i_ref_clk) disable iff (!i_reset_n) (!is_tx || is_cont) |-> !o_tx_start;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start outside transmit");
endmodule

/* File: testbench/rism_host_model.sv */
// Host-side model that resolves the lock pin as the board sees it.
`timescale 1ns/10ps
module rism_host_model (
  // Pins from the device.
  input wire logic i_lock_out,
  input wire logic i_lock_oe_n,
  // Resolved pin level.
  output logic o_lock_pin
);
  // The board pulls the line low, so a released pin never shows a stale level.
  assign o_lock_pin = i_lock_oe_n ? 1'b0 : i_lock_out;
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the interrupt source mapping block.
`timescale 1ns/10ps
module tb_top import rism_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, afe = 1'b0, bclk = 1'b0, seen = 1'b0, err;
  logic [7:0] paddr = 8'h00, level = 8'h00, sel = 8'h00, fil = 8'h01;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, fill_en, qclr, txs_o, irq0, irq1, lock_out, lock_oe_n, lock_pin;
  rism_evt_s evt = '0;
  rism_q_s q = 3'h2;
  int failures = 0, tests_run = 0, seed = 68789, om = 0, dm = 0, r;
  always #25 clk = ~clk;
  always @(negedge clk) if (qclr === 1'b1) seen = 1'b1;
  rism_top DUT (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_evt(evt), .i_q(q), .i_level(level), .i_addr_filter_en(afe), .i_bit_clock_pin(bclk),
    .o_fill_en(fill_en), .o_queue_clear(qclr), .o_tx_start(txs_o), .o_irq0(irq0), .o_irq1(irq1),
    .o_lock_out(lock_out), .o_lock_oe_n(lock_oe_n));
  rism_host_model host (.i_lock_out(lock_out), .i_lock_oe_n(lock_oe_n), .o_lock_pin(lock_pin));
  // ********************
  // Checking and bus tasks.
  // ********************
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read data and the error flag are taken at the edge where pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      failures++;
      end_of_test();
    end
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic pulse_evt(input rism_evt_s e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
  endtask
  // The signal-level flag stays clear here because the level input is zero.
  function automatic logic e0();
    if (om == 2) return (dm == 1 || fil[4]) ? !q.empty : q.at_threshold;
    if (dm == 0) return sel[7:6] == 2'h1 ? 1'b0 : evt.sync;
    if (sel[7:6] == 2'h0) return dm == 1 ? 1'b0 : evt.payload_ready;
    if (sel[7:6] == 2'h1) return evt.byte_written;
    if (sel[7:6] == 2'h2) return !q.empty;
    return (dm > 1 && afe) ? evt.addr_match : evt.sync;
  endfunction
  function automatic logic e1();
    if (dm == 0) return 1'b0;
    if (om == 2) return sel[3] ? 1'b0 : q.full;
    if (sel[5:4] == 2'h0) return dm == 1 ? 1'b0 : evt.crc_ok;
    if (sel[5:4] == 2'h1) return q.full;
    return sel[5:4] == 2'h3 ? q.at_threshold : 1'b0;
  endfunction
  function automatic logic etx();
    if (fil[4]) return !q.empty;
    return dm == 1 ? q.full : q.at_threshold;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(RISM_ADDR_SEL, 32'h00000000);
    rdchk(RISM_ADDR_FILL, 32'h00000001);
    rdchk(RISM_ADDR_THR, 32'h00000000);
    rdchk(8'h50, 32'h00000000);
    chk_pin(err, 1'b1);
    chk_pin(lock_oe_n, 1'b0);
    for (int o = 0; o < 4; o++) begin
      for (int d = 0; d < 4; d++) begin
        for (int i = 0; i < 3; i++) begin
          om = o;
          dm = d;
          sel = 8'($random(seed)) & 8'hF8;
          fil = 8'h01 | (8'($random(seed)) & 8'h10);
          apb(1'b1, RISM_ADDR_SEL, sel);
          apb(1'b1, RISM_ADDR_FILL, fil);
          apb(1'b1, RISM_ADDR_MODE, 8'(o * 4 + d));
          r = $random(seed);
          @(posedge clk);
          evt <= {r[5:0], 3'h0};
          q <= r[8:6];
          afe <= r[9];
          @(negedge clk);
          if (o != 2 || d != 0) chk_pin(irq0, e0());
          chk_pin(irq1, e1());
          if (o == 2 && d != 0) chk_pin(txs_o, etx());
        end
      end
    end
    @(posedge clk);
    evt <= '0;
    q <= 3'h2;
    apb(1'b1, RISM_ADDR_SEL, 8'h00);
    apb(1'b1, RISM_ADDR_MODE, 8'h04);
    @(posedge clk);
    bclk <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk_pin(irq1, 1'b1);
    apb(1'b1, RISM_ADDR_MODE, 8'h08);
    chk_pin(irq1, 1'b1);
    @(posedge clk);
    bclk <= 1'b0;
    apb(1'b1, RISM_ADDR_MODE, 8'h05);
    apb(1'b1, RISM_ADDR_FILL, 8'h41);
    pulse_evt(9'h100);
    rdchk(RISM_ADDR_FILL, 32'h00000041);
    chk_pin(fill_en, 1'b1);
    @(posedge clk);
    q <= 3'h4;
    pulse_evt(9'h002);
    apb(1'b1, RISM_ADDR_FILL, 8'h41);
    rdchk(RISM_ADDR_FILL, 32'h00000041);
    rdchk(RISM_ADDR_SEL, 32'h00000007);
    @(posedge clk);
    q <= 3'h2;
    seen = 1'b0;
    apb(1'b1, RISM_ADDR_SEL, 8'h01);
    chk_pin(seen, 1'b1);
    rdchk(RISM_ADDR_SEL, 32'h00000000);
    apb(1'b1, RISM_ADDR_FILL, 8'h41);
    rdchk(RISM_ADDR_FILL, 32'h00000001);
    apb(1'b1, RISM_ADDR_FILL, 8'hC1);
    chk_pin(fill_en, 1'b1);
    apb(1'b1, RISM_ADDR_FILL, 8'h81);
    chk_pin(fill_en, 1'b0);
    apb(1'b1, RISM_ADDR_MODE, 8'h0A);
    apb(1'b1, RISM_ADDR_SEL, 8'h08);
    pulse_evt(9'h004);
    rdchk(RISM_ADDR_FILL, 32'h000000A1);
    chk_pin(irq1, 1'b1);
    apb(1'b1, RISM_ADDR_FILL, 8'h01);
    chk_pin(irq1, 1'b0);
    apb(1'b1, RISM_ADDR_THR, 8'h40);
    rdchk(RISM_ADDR_THR, 32'h00000040);
    apb(1'b1, RISM_ADDR_MODE, 8'h04);
    apb(1'b1, RISM_ADDR_SEL, 8'h40);
    apb(1'b1, RISM_ADDR_FILL, 8'h09);
    @(posedge clk);
    level <= 8'h40;
    rdchk(RISM_ADDR_FILL, 32'h00000009);
    @(posedge clk);
    level <= 8'h41;
    @(posedge clk);
    level <= 8'h00;
    rdchk(RISM_ADDR_FILL, 32'h0000000D);
    chk_pin(irq0, 1'b1);
    apb(1'b1, RISM_ADDR_FILL, 8'h0D);
    rdchk(RISM_ADDR_FILL, 32'h00000009);
    apb(1'b1, RISM_ADDR_FILL, 8'h01);
    @(posedge clk);
    level <= 8'hFF;
    rdchk(RISM_ADDR_FILL, 32'h00000001);
    @(posedge clk);
    level <= 8'h00;
    pulse_evt(9'h001);
    rdchk(RISM_ADDR_FILL, 32'h00000003);
    chk_pin(lock_pin, 1'b1);
    apb(1'b1, RISM_ADDR_FILL, 8'h00);
    chk_pin(lock_oe_n, 1'b1);
    chk_pin(lock_pin, 1'b0);
    apb(1'b1, RISM_ADDR_FILL, 8'h03);
    rdchk(RISM_ADDR_FILL, 32'h00000001);
    end_of_test();
  end
endmodule
